// ==== inc/dcbs_consts.svh ====
`ifndef DCBS_CONSTS_SVH
`define DCBS_CONSTS_SVH

// Clock and array timing, in ns, at the 100 MHz device clock
`define DCBS_TCK_NS 10
`define DCBS_TRP_NS 15
`define DCBS_TRCD_NS 15
`define DCBS_TRFC_NS 70
`define DCBS_TMRD_NS 10
`define DCBS_TREFI_NS 7800

// Least times round up, the refresh interval is a longest time and rounds down
`define DCBS_TRP_CYC ((`DCBS_TRP_NS + `DCBS_TCK_NS - 1) / `DCBS_TCK_NS)
`define DCBS_TRCD_CYC ((`DCBS_TRCD_NS + `DCBS_TCK_NS - 1) / `DCBS_TCK_NS)
`define DCBS_TRFC_CYC ((`DCBS_TRFC_NS + `DCBS_TCK_NS - 1) / `DCBS_TCK_NS)
`define DCBS_TMRD_CYC ((`DCBS_TMRD_NS + `DCBS_TCK_NS - 1) / `DCBS_TCK_NS)
`define DCBS_TREFI_CYC (`DCBS_TREFI_NS / `DCBS_TCK_NS)

// Data phase of one burst in clocks (four beats, two per clock)
`define DCBS_BURST_CYC 2

// Address fields
`define DCBS_AP_BIT 10
`define DCBS_ROW_MSB_128M 4'hb
`define DCBS_ROW_MSB_256M 4'hc
`define DCBS_ROW_MSB_1G 4'hd
`define DCBS_ROW_MASK 14'h3fff

`endif

// ==== inc/dcbs_pkg.sv ====
package dcbs_pkg;
   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_SREF, CMD_LMR
   } dcbs_cmd_t;
   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_READ_AP, BK_WRITE_AP,
      BK_PRECHARGING
   } dcbs_bank_st_t;
   typedef enum logic [1:0] {BUR_NONE, BUR_READ, BUR_WRITE} dcbs_burst_t;
   typedef enum logic [1:0] {GL_RUN, GL_BUSY, GL_SREF} dcbs_glob_t;
   typedef logic [3:0] dcbs_tmr_t;
   typedef logic [13:0] dcbs_addr_t;
endpackage

// ==== inc/dcbs_bank_if.sv ====
`timescale 1ns/1ns
// Command strobes from the decoder to one bank, bank state back
interface dcbs_bank_if;
   logic act;
   logic rd;
   logic wr;
   logic ap;
   logic pre;
   logic burst_end;
   dcbs_pkg::dcbs_bank_st_t state;
   modport ctl (output act, rd, wr, ap, pre, burst_end, input state);
   modport bank (input act, rd, wr, ap, pre, burst_end, output state);
endinterface

// ==== design/dcbs_bank.sv ====
`timescale 1ns/1ns
`include "dcbs_consts.svh"
module dcbs_bank (
   input wire logic clk,
   input wire logic rst_n,
   dcbs_bank_if.bank bus
);
   dcbs_pkg::dcbs_bank_st_t st_reg, st_next;
   dcbs_pkg::dcbs_tmr_t tmr_reg, tmr_next;

   assign bus.state = st_reg;

   // Bank sequence; illegal strobes never arrive, the decoder filters them
   always_comb begin
      st_next = st_reg;
      tmr_next = (tmr_reg != 4'h0) ? tmr_reg - 4'h1 : tmr_reg;
      case (st_reg)
         dcbs_pkg::BK_IDLE: begin
            if (bus.act) begin
               st_next = dcbs_pkg::BK_ACTIVATING;
               tmr_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_TRCD_CYC);
            end
         end
         dcbs_pkg::BK_ACTIVATING: begin
            if (tmr_reg == 4'h1) st_next = dcbs_pkg::BK_ACTIVE;
         end
         dcbs_pkg::BK_ACTIVE, dcbs_pkg::BK_READ, dcbs_pkg::BK_WRITE: begin
            if (bus.pre) begin
               st_next = dcbs_pkg::BK_PRECHARGING;
               tmr_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_TRP_CYC);
            end else if (bus.rd) begin
               st_next = bus.ap ? dcbs_pkg::BK_READ_AP : dcbs_pkg::BK_READ;
            end else if (bus.wr) begin
               st_next = bus.ap ? dcbs_pkg::BK_WRITE_AP : dcbs_pkg::BK_WRITE;
            end else if (bus.burst_end && st_reg != dcbs_pkg::BK_ACTIVE) begin
               st_next = dcbs_pkg::BK_ACTIVE;
            end
         end
         dcbs_pkg::BK_READ_AP, dcbs_pkg::BK_WRITE_AP: begin
            // Nothing else reaches the bank until its own precharge is over
            if (bus.burst_end) begin
               st_next = dcbs_pkg::BK_PRECHARGING;
               tmr_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_TRP_CYC);
            end
         end
         dcbs_pkg::BK_PRECHARGING: begin
            if (tmr_reg == 4'h1) st_next = dcbs_pkg::BK_IDLE;
         end
         default: st_next = dcbs_pkg::BK_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= dcbs_pkg::BK_IDLE;
         tmr_reg <= 4'h0;
      end else begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_BANK_TRCD: assert property (
      (st_reg == dcbs_pkg::BK_IDLE && bus.act) |=>
      (st_reg == dcbs_pkg::BK_ACTIVATING)[*2] ##1 (st_reg == dcbs_pkg::BK_ACTIVE))
      else $error("bank left activating at the wrong time");
   AST_BANK_TRP: assert property (
      (bus.pre && (st_reg == dcbs_pkg::BK_ACTIVE || st_reg == dcbs_pkg::BK_READ)) |=>
      (st_reg == dcbs_pkg::BK_PRECHARGING)[*2] ##1 (st_reg == dcbs_pkg::BK_IDLE))
      else $error("precharge did not last the row precharge time");
   AST_BANK_AUTO_PRE: assert property (
      ((st_reg == dcbs_pkg::BK_READ_AP || st_reg == dcbs_pkg::BK_WRITE_AP) && bus.burst_end)
      |=> (st_reg == dcbs_pkg::BK_PRECHARGING)[*2] ##1 (st_reg == dcbs_pkg::BK_IDLE))
      else $error("auto precharge did not return the bank to idle");
   AST_BANK_IDLE_ENTRY: assert property (
      $rose(st_reg == dcbs_pkg::BK_IDLE) |-> $past(st_reg) == dcbs_pkg::BK_PRECHARGING)
      else $error("bank became idle without precharging");
endmodule // dcbs_bank

// ==== design/dcbs_refresh_ctr.sv ====
`timescale 1ns/1ns
`include "dcbs_consts.svh"
module dcbs_refresh_ctr (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic [3:0] row_msb,
   output dcbs_pkg::dcbs_addr_t row
);
   dcbs_pkg::dcbs_addr_t row_reg, row_next, mask;

   assign row = row_reg;

   // Row counter wraps at the top row of the selected density
   always_comb begin
      mask = `DCBS_ROW_MASK >> (4'hd - row_msb);
      row_next = step ? ((row_reg + 14'h0001) & mask) : row_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) row_reg <= 14'h0000;
      else row_reg <= row_next;
   end
endmodule // dcbs_refresh_ctr

// ==== design/dcbs_cmd_bank.sv ====
`timescale 1ns/1ns
`include "dcbs_consts.svh"
// Functional notes
// - Deselect acts as no-operation, work continues
// - ACTIVE opens given row in given bank
// - Row address top bit follows density
// - Column access: write enable picks read/write
// - Address bit 10 selects one-shot auto precharge
// - Precharge closes one bank or all
// - Refresh pattern: clock enable picks auto/self
// - Self refresh counts rows, ignores other pins
// - Mode load picks base or extended register
// - High data mask blocks that write beat
// - Idle only after precharge time has passed
// - Activating lasts the row-to-column delay
// - Precharging bank takes no command
// - Auto-precharge access ends idle after precharge
// - Refresh blocks all commands for refresh time
// - Mode load blocks commands for set delay
// - Precharge-all blocks commands for precharge time
// - Read burst: read/precharge truncate, write waits
// - Write burst: truncation masks remaining beats
module dcbs_cmd_bank (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire dcbs_pkg::dcbs_addr_t addr,
   input wire logic dm,
   input wire logic [7:0] dq,
   input wire logic [1:0] density,
   output dcbs_pkg::dcbs_cmd_t cmd_code,
   output logic [1:0] cmd_bank,
   output dcbs_pkg::dcbs_addr_t cmd_addr,
   output logic cmd_violation,
   output dcbs_pkg::dcbs_bank_st_t [3:0] bank_state,
   output logic mode_load,
   output logic mode_ext,
   output dcbs_pkg::dcbs_addr_t mode_opcode,
   output logic refresh_pulse,
   output dcbs_pkg::dcbs_addr_t refresh_row,
   output logic self_refresh,
   output logic wr_beat_en,
   output logic [7:0] wr_data
);
   dcbs_pkg::dcbs_cmd_t cmd;
   logic ok, viol, all_idle, all_pre_ok, bur_hit, ap, step;
   logic [3:0] sel_v, act_v, rd_v, wr_v, pre_v, end_v;
   dcbs_pkg::dcbs_burst_t bur_kind_reg, bur_kind_next;
   logic [1:0] bur_bank_reg, bur_bank_next;
   logic bur_ap_reg, bur_ap_next;
   dcbs_pkg::dcbs_tmr_t bur_cnt_reg, bur_cnt_next;
   dcbs_pkg::dcbs_glob_t glob_reg, glob_next;
   dcbs_pkg::dcbs_tmr_t gtmr_reg, gtmr_next;
   logic [9:0] tick_reg, tick_next;
   logic [3:0] row_msb_reg, row_msb_next;
   dcbs_pkg::dcbs_cmd_t cmd_code_reg, cmd_code_next;
   logic [1:0] cmd_bank_reg, cmd_bank_next;
   dcbs_pkg::dcbs_addr_t cmd_addr_reg, cmd_addr_next, mode_opcode_reg, mode_opcode_next;
   logic viol_reg, viol_next, mode_load_reg, mode_load_next, mode_ext_reg, mode_ext_next;
   logic ref_pulse_reg, ref_pulse_next, sref_reg, sref_next, wr_en_reg, wr_en_next;
   logic [7:0] wr_data_reg, wr_data_next;

   // Banks a precharge may legally reach
   function automatic logic pre_legal(input dcbs_pkg::dcbs_bank_st_t s);
      pre_legal = (s == dcbs_pkg::BK_IDLE) || (s == dcbs_pkg::BK_ACTIVE) ||
         (s == dcbs_pkg::BK_READ) || (s == dcbs_pkg::BK_WRITE);
   endfunction

   // Banks that take a column access
   function automatic logic rw_legal(input dcbs_pkg::dcbs_bank_st_t s);
      rw_legal = (s == dcbs_pkg::BK_ACTIVE) || (s == dcbs_pkg::BK_READ) ||
         (s == dcbs_pkg::BK_WRITE);
   endfunction

   // Command decode and legality check on the pins at each rising edge
   always_comb begin
      cmd = dcbs_pkg::CMD_NOP;
      if (!cs_n && glob_reg != dcbs_pkg::GL_SREF) begin
         case ({ras_n, cas_n, we_n})
            3'h3: cmd = dcbs_pkg::CMD_ACT;
            3'h5: cmd = dcbs_pkg::CMD_RD;
            3'h4: cmd = dcbs_pkg::CMD_WR;
            3'h6: cmd = dcbs_pkg::CMD_BST;
            3'h2: cmd = dcbs_pkg::CMD_PRE;
            3'h1: cmd = cke ? dcbs_pkg::CMD_REF : dcbs_pkg::CMD_SREF;
            3'h0: cmd = dcbs_pkg::CMD_LMR;
            default: cmd = dcbs_pkg::CMD_NOP;
         endcase
      end
      all_idle = 1'b1;
      all_pre_ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         all_idle = all_idle && (bank_state[i] == dcbs_pkg::BK_IDLE);
         all_pre_ok = all_pre_ok && pre_legal(bank_state[i]);
      end
      bur_hit = (bur_kind_reg != dcbs_pkg::BUR_NONE);
      case (cmd)
         dcbs_pkg::CMD_ACT: ok = (bank_state[ba] == dcbs_pkg::BK_IDLE);
         dcbs_pkg::CMD_RD: ok = rw_legal(bank_state[ba]);
         dcbs_pkg::CMD_WR: begin
            ok = rw_legal(bank_state[ba]) && (bur_kind_reg != dcbs_pkg::BUR_READ);
         end
         dcbs_pkg::CMD_BST: begin
            ok = (bur_kind_reg == dcbs_pkg::BUR_READ) && !bur_ap_reg;
         end
         dcbs_pkg::CMD_PRE: begin
            ok = addr[`DCBS_AP_BIT] ? all_pre_ok : pre_legal(bank_state[ba]);
         end
         dcbs_pkg::CMD_REF, dcbs_pkg::CMD_SREF: ok = all_idle && !bur_hit;
         dcbs_pkg::CMD_LMR: ok = all_idle && !bur_hit && !ba[1];
         default: ok = 1'b1;
      endcase
      if (glob_reg == dcbs_pkg::GL_BUSY && cmd != dcbs_pkg::CMD_NOP) begin
         ok = 1'b0;
      end
      viol = !ok;
      // A refused command sends no strobe, so no bank moves
      sel_v = 4'h1 << ba;
      act_v = (ok && cmd == dcbs_pkg::CMD_ACT) ? sel_v : 4'h0;
      rd_v = (ok && cmd == dcbs_pkg::CMD_RD) ? sel_v : 4'h0;
      wr_v = (ok && cmd == dcbs_pkg::CMD_WR) ? sel_v : 4'h0;
      ap = addr[`DCBS_AP_BIT];
      pre_v = 4'h0;
      if (ok && cmd == dcbs_pkg::CMD_PRE) begin
         pre_v = addr[`DCBS_AP_BIT] ? 4'hf : sel_v;
      end
      // A burst ends by running out, by a new access, or by burst terminate
      end_v = 4'h0;
      if (bur_hit && (bur_cnt_reg == 4'h1 || (ok && (cmd == dcbs_pkg::CMD_RD ||
          cmd == dcbs_pkg::CMD_WR || cmd == dcbs_pkg::CMD_BST)))) begin
         end_v = 4'h1 << bur_bank_reg;
      end
   end

   // Bank trackers, one per bank
   dcbs_bank_if bif [4] ();
   for (genvar gi = 0; gi < 4; gi++) begin : g_bank
      assign bif[gi].act = act_v[gi];
      assign bif[gi].rd = rd_v[gi];
      assign bif[gi].wr = wr_v[gi];
      assign bif[gi].ap = ap;
      assign bif[gi].pre = pre_v[gi];
      assign bif[gi].burst_end = end_v[gi];
      assign bank_state[gi] = bif[gi].state;
      dcbs_bank u_bank (
         .clk(clk),
         .rst_n(rst_n),
         .bus(bif[gi])
      );
   end

   // Data burst tracking; only one burst owns the data pins at a time
   always_comb begin
      bur_kind_next = bur_kind_reg;
      bur_bank_next = bur_bank_reg;
      bur_ap_next = bur_ap_reg;
      bur_cnt_next = bur_cnt_reg;
      if (ok && (cmd == dcbs_pkg::CMD_RD || cmd == dcbs_pkg::CMD_WR)) begin
         bur_kind_next = (cmd == dcbs_pkg::CMD_RD) ? dcbs_pkg::BUR_READ : dcbs_pkg::BUR_WRITE;
         bur_bank_next = ba;
         bur_ap_next = addr[`DCBS_AP_BIT];
         bur_cnt_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_BURST_CYC);
      end else if (bur_hit && (bur_cnt_reg == 4'h1 || (ok && cmd == dcbs_pkg::CMD_BST) ||
                   pre_v[bur_bank_reg])) begin
         // Truncation drops the rest of a write, as if those beats were masked
         bur_kind_next = dcbs_pkg::BUR_NONE;
         bur_ap_next = 1'b0;
         bur_cnt_next = 4'h0;
      end else if (bur_hit) begin
         bur_cnt_next = bur_cnt_reg - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bur_kind_reg <= dcbs_pkg::BUR_NONE;
         bur_bank_reg <= 2'h0;
         bur_ap_reg <= 1'b0;
         bur_cnt_reg <= 4'h0;
      end else begin
         bur_kind_reg <= bur_kind_next;
         bur_bank_reg <= bur_bank_next;
         bur_ap_reg <= bur_ap_next;
         bur_cnt_reg <= bur_cnt_next;
      end
   end

   // Device-wide waits and self refresh
   always_comb begin
      glob_next = glob_reg;
      gtmr_next = gtmr_reg;
      tick_next = tick_reg;
      step = 1'b0;
      case (density)
         2'h0: row_msb_next = `DCBS_ROW_MSB_128M;
         2'h3: row_msb_next = `DCBS_ROW_MSB_1G;
         default: row_msb_next = `DCBS_ROW_MSB_256M;
      endcase
      case (glob_reg)
         dcbs_pkg::GL_RUN: begin
            if (ok && cmd == dcbs_pkg::CMD_REF) begin
               glob_next = dcbs_pkg::GL_BUSY;
               gtmr_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_TRFC_CYC);
               step = 1'b1;
            end else if (ok && cmd == dcbs_pkg::CMD_LMR) begin
               glob_next = dcbs_pkg::GL_BUSY;
               gtmr_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_TMRD_CYC);
            end else if (ok && cmd == dcbs_pkg::CMD_PRE && addr[`DCBS_AP_BIT]) begin
               glob_next = dcbs_pkg::GL_BUSY;
               gtmr_next = dcbs_pkg::dcbs_tmr_t'(`DCBS_TRP_CYC);
            end else if (ok && cmd == dcbs_pkg::CMD_SREF) begin
               glob_next = dcbs_pkg::GL_SREF;
               tick_next = 10'(`DCBS_TREFI_CYC);
               step = 1'b1;
            end
         end
         dcbs_pkg::GL_BUSY: begin
            if (gtmr_reg == 4'h1) glob_next = dcbs_pkg::GL_RUN;
            else gtmr_next = gtmr_reg - 4'h1;
         end
         dcbs_pkg::GL_SREF: begin
            // Only clock enable matters here; the row counter runs by itself
            if (cke) begin
               glob_next = dcbs_pkg::GL_RUN;
            end else if (tick_reg == 10'h001) begin
               step = 1'b1;
               tick_next = 10'(`DCBS_TREFI_CYC);
            end else begin
               tick_next = tick_reg - 10'h001;
            end
         end
         default: glob_next = dcbs_pkg::GL_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         glob_reg <= dcbs_pkg::GL_RUN;
         gtmr_reg <= 4'h0;
         tick_reg <= 10'h000;
         row_msb_reg <= `DCBS_ROW_MSB_1G;
      end else begin
         glob_reg <= glob_next;
         gtmr_reg <= gtmr_next;
         tick_reg <= tick_next;
         row_msb_reg <= row_msb_next;
      end
   end

   // Internal refresh row source
   dcbs_refresh_ctr u_refresh (
      .clk(clk),
      .rst_n(rst_n),
      .step(step),
      .row_msb(row_msb_reg),
      .row(refresh_row)
   );

   // Registered command report, mode load and write data path
   always_comb begin
      cmd_code_next = cmd;
      cmd_bank_next = ba;
      cmd_addr_next = addr;
      viol_next = viol;
      mode_load_next = ok && cmd == dcbs_pkg::CMD_LMR;
      mode_ext_next = mode_load_next ? ba[0] : mode_ext_reg;
      mode_opcode_next = mode_load_next ? addr : mode_opcode_reg;
      ref_pulse_next = ok && cmd == dcbs_pkg::CMD_REF;
      sref_next = (glob_next == dcbs_pkg::GL_SREF);
      wr_en_next = (bur_kind_reg == dcbs_pkg::BUR_WRITE) && !dm;
      wr_data_next = wr_en_next ? dq : wr_data_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_code_reg <= dcbs_pkg::CMD_NOP;
         cmd_bank_reg <= 2'h0;
         cmd_addr_reg <= 14'h0000;
         viol_reg <= 1'b0;
         mode_load_reg <= 1'b0;
         mode_ext_reg <= 1'b0;
         mode_opcode_reg <= 14'h0000;
         ref_pulse_reg <= 1'b0;
         sref_reg <= 1'b0;
         wr_en_reg <= 1'b0;
         wr_data_reg <= 8'h00;
      end else begin
         cmd_code_reg <= cmd_code_next;
         cmd_bank_reg <= cmd_bank_next;
         cmd_addr_reg <= cmd_addr_next;
         viol_reg <= viol_next;
         mode_load_reg <= mode_load_next;
         mode_ext_reg <= mode_ext_next;
         mode_opcode_reg <= mode_opcode_next;
         ref_pulse_reg <= ref_pulse_next;
         sref_reg <= sref_next;
         wr_en_reg <= wr_en_next;
         wr_data_reg <= wr_data_next;
      end
   end

   assign cmd_code = cmd_code_reg;
   assign cmd_bank = cmd_bank_reg;
   assign cmd_addr = cmd_addr_reg;
   assign cmd_violation = viol_reg;
   assign mode_load = mode_load_reg;
   assign mode_ext = mode_ext_reg;
   assign mode_opcode = mode_opcode_reg;
   assign refresh_pulse = ref_pulse_reg;
   assign self_refresh = sref_reg;
   assign wr_beat_en = wr_en_reg;
   assign wr_data = wr_data_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_DESELECT_IS_NOP: assert property (
      cs_n |=> (cmd_code == dcbs_pkg::CMD_NOP) && !cmd_violation)
      else $error("deselect was not treated as no-operation");
   AST_AP_ONE_SHOT: assert property (
      (ok && cmd == dcbs_pkg::CMD_RD && !addr[`DCBS_AP_BIT]) |=> !bur_ap_reg)
      else $error("auto precharge carried into a later access");
   AST_BST_ENDS_READ: assert property (
      (ok && cmd == dcbs_pkg::CMD_BST) |=> (bur_kind_reg == dcbs_pkg::BUR_NONE))
      else $error("burst terminate left the read burst running");
   AST_WRITE_WAITS_READ: assert property (
      (cmd == dcbs_pkg::CMD_WR && bur_kind_reg == dcbs_pkg::BUR_READ) |=> cmd_violation)
      else $error("write accepted during a read burst");
   AST_SREF_ENTRY: assert property (
      (ok && cmd == dcbs_pkg::CMD_SREF) |=> self_refresh && $changed(refresh_row))
      else $error("self refresh entry missed");
   AST_SREF_IGNORES: assert property (
      (self_refresh && !cke) |=> self_refresh && (cmd_code == dcbs_pkg::CMD_NOP))
      else $error("pins were decoded during self refresh");
   AST_REFRESH_WAIT: assert property (
      (ok && cmd == dcbs_pkg::CMD_REF) |=> (glob_reg == dcbs_pkg::GL_BUSY)[*7]
      ##1 (glob_reg == dcbs_pkg::GL_RUN))
      else $error("refresh cycle time not held");
   AST_LMR_WAIT: assert property (
      (ok && cmd == dcbs_pkg::CMD_LMR) |=> mode_load && (glob_reg == dcbs_pkg::GL_BUSY)
      ##1 (glob_reg == dcbs_pkg::GL_RUN) && all_idle)
      else $error("mode load delay not held");
   AST_PREA_WAIT: assert property (
      (ok && cmd == dcbs_pkg::CMD_PRE && addr[`DCBS_AP_BIT]) |=>
      (glob_reg == dcbs_pkg::GL_BUSY)[*2] ##1 (glob_reg == dcbs_pkg::GL_RUN && all_idle))
      else $error("precharge all did not end with all banks idle");
   AST_DM_MASK: assert property (
      (bur_kind_reg == dcbs_pkg::BUR_WRITE) |=> (wr_beat_en == !$past(dm)))
      else $error("data mask not applied to write beat");
   AST_VIOL_NO_STROBE: assert property (
      viol |-> ((act_v | rd_v | wr_v | pre_v) == 4'h0) ##1 cmd_violation)
      else $error("refused command reached a bank");
endmodule // dcbs_cmd_bank

// ==== verif/dcbs_ctl_model.sv ====
`timescale 1ns/1ns
// Controller stand-in: pins move only at falling edges, one command per rising edge
module dcbs_ctl_model (
   input wire logic clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output dcbs_pkg::dcbs_addr_t addr,
   output logic dm,
   output logic [7:0] dq
);
   // Idle bus: NOP with the write mask up, so stray beats never land
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      ba = 2'h0;
      addr = 14'h0000;
      dm = 1'b1;
      dq = 8'h00;
   end
   // Called at a falling edge; the command stands over one rising edge and stays
   // until the next call, so back-to-back commands never write a pin twice at once
   task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic [13:0] a);
      {cs_n, ras_n, cas_n, we_n} = code;
      ba = b;
      addr = a;
      @(negedge clk);
   endtask
   // NOP for n rising edges
   task automatic idle(input int n);
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      repeat (n) @(negedge clk);
   endtask
   // Clock enable level, changed at a falling edge
   task automatic set_cke(input logic v);
      cke = v;
   endtask
   // One write beat with its mask under NOP, presented for one rising edge
   task automatic beat(input logic m, input logic [7:0] d);
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      dm = m;
      dq = d;
      @(negedge clk);
   endtask
endmodule // dcbs_ctl_model

// ==== verif/test_ddr_sdram_command_bank_state.sv ====
`timescale 1ns/1ns
module test_ddr_sdram_command_bank_state;
   logic clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, dm, mode_load, mode_ext, refresh_pulse;
   logic cmd_violation, self_refresh, wr_beat_en;
   logic [1:0] ba, cmd_bank;
   logic [7:0] dq, wr_data, d1;
   dcbs_pkg::dcbs_addr_t addr, cmd_addr, mode_opcode, refresh_row, a;
   dcbs_pkg::dcbs_cmd_t cmd_code;
   dcbs_pkg::dcbs_bank_st_t [3:0] bank_state;
   int n_mismatch = 0, num_checks = 0, exp_st[4];
   integer seed = 32'hc191_c358;
   dcbs_ctl_model i_dcbs_ctl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm), .dq(dq));
   dcbs_cmd_bank i_dcbs_cmd_bank (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm), .dq(dq),
      .density(2'h3), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
      .cmd_violation(cmd_violation), .bank_state(bank_state), .mode_load(mode_load),
      .mode_ext(mode_ext), .mode_opcode(mode_opcode), .refresh_pulse(refresh_pulse),
      .refresh_row(refresh_row), .self_refresh(self_refresh), .wr_beat_en(wr_beat_en),
      .wr_data(wr_data));
   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Bank model against the four state outputs
   task automatic banks();
      for (int i = 0; i < 4; i++) chk({29'h0, bank_state[i]}, exp_st[i]);
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog well beyond the 56 cycles the sequence needs
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      exp_st = '{default: dcbs_pkg::BK_IDLE};
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk(cmd_code, dcbs_pkg::CMD_NOP);
      chk(refresh_row, 14'h0000);
      banks();
      i_dcbs_ctl_model.issue(4'h1, 2'h0, 14'h0000);
      chk(refresh_pulse, 1'b1);
      chk(refresh_row, 14'h0001);
      // Anything but NOP inside the refresh time is refused
      i_dcbs_ctl_model.issue(4'h3, 2'h0, 14'h0000);
      chk(cmd_violation, 1'b1);
      banks();
      i_dcbs_ctl_model.idle(6);
      a = 14'($random(seed));
      i_dcbs_ctl_model.issue(4'h0, 2'h1, a);
      chk(mode_load, 1'b1);
      chk(mode_ext, 1'b1);
      chk(mode_opcode, a);
      i_dcbs_ctl_model.idle(1);
      // Open bank 0, then a second open to the busy bank is refused
      i_dcbs_ctl_model.issue(4'h3, 2'h0, a);
      chk(cmd_code, dcbs_pkg::CMD_ACT);
      exp_st[0] = dcbs_pkg::BK_ACTIVATING;
      banks();
      i_dcbs_ctl_model.issue(4'h3, 2'h0, a);
      chk(cmd_violation, 1'b1);
      banks();
      exp_st[0] = dcbs_pkg::BK_ACTIVE;
      i_dcbs_ctl_model.issue(4'h3, 2'h1, a);
      exp_st[1] = dcbs_pkg::BK_ACTIVATING;
      banks();
      // Bank 1 takes a column access only once its activation time is over
      i_dcbs_ctl_model.idle(2);
      // Write to bank 1: first beat enabled, second masked
      d1 = 8'($random(seed));
      i_dcbs_ctl_model.issue(4'h4, 2'h1, 14'h0008);
      chk(cmd_code, dcbs_pkg::CMD_WR);
      i_dcbs_ctl_model.beat(1'b0, d1);
      chk(wr_beat_en, 1'b1);
      chk(wr_data, d1);
      i_dcbs_ctl_model.beat(1'b1, ~d1);
      chk(wr_beat_en, 1'b0);
      i_dcbs_ctl_model.idle(2);
      i_dcbs_ctl_model.issue(4'h2, 2'h2, 14'h0400);
      chk({29'h0, bank_state[0]}, dcbs_pkg::BK_PRECHARGING);
      i_dcbs_ctl_model.idle(3);
      exp_st = '{default: dcbs_pkg::BK_IDLE};
      banks();
      // Read with auto precharge; burst terminate is not for it
      i_dcbs_ctl_model.issue(4'h3, 2'h2, a);
      i_dcbs_ctl_model.idle(2);
      i_dcbs_ctl_model.issue(4'h5, 2'h2, 14'h0404);
      chk({29'h0, bank_state[2]}, dcbs_pkg::BK_READ_AP);
      chk(cmd_addr, 14'h0404);
      i_dcbs_ctl_model.issue(4'h6, 2'h2, 14'h0000);
      chk(cmd_violation, 1'b1);
      i_dcbs_ctl_model.idle(4);
      banks();
      // Plain read on bank 3: write waits, terminate ends it, then one-bank precharge
      i_dcbs_ctl_model.issue(4'h3, 2'h3, a);
      i_dcbs_ctl_model.idle(2);
      i_dcbs_ctl_model.issue(4'h5, 2'h3, 14'h0000);
      i_dcbs_ctl_model.issue(4'h4, 2'h3, 14'h0000);
      chk(cmd_violation, 1'b1);
      chk(cmd_bank, 2'h3);
      i_dcbs_ctl_model.issue(4'h5, 2'h3, 14'h0000);
      i_dcbs_ctl_model.issue(4'h6, 2'h0, 14'h0000);
      chk(cmd_violation, 1'b0);
      chk({29'h0, bank_state[3]}, dcbs_pkg::BK_ACTIVE);
      i_dcbs_ctl_model.issue(4'h2, 2'h3, 14'h0000);
      exp_st[3] = dcbs_pkg::BK_PRECHARGING;
      banks();
      exp_st[3] = dcbs_pkg::BK_IDLE;
      i_dcbs_ctl_model.idle(2);
      // Self refresh: only clock enable counts until it rises again
      i_dcbs_ctl_model.set_cke(1'b0);
      i_dcbs_ctl_model.issue(4'h1, 2'h0, 14'h0000);
      chk(self_refresh, 1'b1);
      chk(cmd_code, dcbs_pkg::CMD_SREF);
      chk(refresh_row, 14'h0002);
      i_dcbs_ctl_model.issue(4'h3, 2'h0, a);
      chk(cmd_code, dcbs_pkg::CMD_NOP);
      chk(cmd_violation, 1'b0);
      banks();
      i_dcbs_ctl_model.set_cke(1'b1);
      i_dcbs_ctl_model.idle(1);
      chk(self_refresh, 1'b0);
      // Deselect with random other pins behaves as NOP
      for (int i = 0; i < 4; i++) begin
         i_dcbs_ctl_model.issue({1'b1, 3'($random(seed))}, 2'($random(seed)), a);
         chk(cmd_code, dcbs_pkg::CMD_NOP);
         chk(cmd_violation, 1'b0);
      end
      test_done();
   end
endmodule // test_ddr_sdram_command_bank_state
